// ==== dv/host_mcu_model.sv ====
`timescale 1ns/10ps
module host_mcu_model (
  // clock
  input  wire logic       sys_clk,
  // request from bench
  input  wire logic       req,
  input  wire logic [3:0] cmd,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] data,
  input  wire logic [4:0] nbits,
  input  wire logic       rb,
  input  wire logic [1:0] src,
  output logic            done,
  output logic [7:0]      rd_byte,
  // serial pins
  output logic            select_n_pin,
  output logic            serial_clock_pin,
  output logic            data_out,
  output logic            data_oe,
  input  wire logic       data_wire,
  input  wire logic       ask_out,
  input  wire logic       fsk_out
);
  // slow serial clock, each level well above the pin synchroniser latency
  localparam int HALF = 8;
  logic [15:0] frame;
  logic        smp;

  initial begin
    select_n_pin     = 1'b1;
    serial_clock_pin = 1'b0;
    data_out         = 1'b0;
    data_oe          = 1'b1;
    done             = 1'b0;
    rd_byte          = 8'h00;
    forever begin
      @(posedge sys_clk);
      done <= 1'b0;
      if (req === 1'b1) begin
        frame = {cmd, addr, data};
        data_oe      <= !rb;
        select_n_pin <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
          data_out <= frame[15-i];
          repeat (HALF) @(posedge sys_clk);
          serial_clock_pin <= 1'b1;
          smp = data_wire;
          if (rb && i < 8)
            rd_byte[7-i] <= smp;
          repeat (HALF) @(posedge sys_clk);
          serial_clock_pin <= 1'b0;
          // four-wire data moves after each falling clock, so take it there
          smp = (src == 2'h1) ? ask_out : fsk_out;
          if (src != 2'h0 && i >= 7 && i < 15)
            rd_byte[14-i] <= smp;
        end
        repeat (HALF) @(posedge sys_clk);
        select_n_pin <= 1'b1;
        // let the device drop its driver before taking the line back
        repeat (6) @(posedge sys_clk);
        data_oe  <= 1'b1;
        data_out <= 1'b0;
        repeat (4) @(posedge sys_clk);
        done <= 1'b1;
      end
    end
  end
endmodule // host_mcu_model

// ==== dv/receiver_serial_control_port_tb.sv ====
`timescale 1ns/10ps
module receiver_serial_control_port_tb;
  logic        sys_clk = 1'b0;
  logic        resetn, req, rb, chk, agc, amp_in, frq_in, done, rel, discontinuous_receive_mode;
  logic [3:0]  cmd, addr;
  logic [7:0]  data, rd_byte, d, divisor, obs;
  logic [4:0]  nbits;
  logic [1:0]  src, track;
  logic        sel_n, sclk, h_out, h_oe, d_out, d_oe, pull, line, ado, fdo, sleep;
  logic [6:0]  pwr_on;
  int          kind_q[$];
  logic [7:0]  exp_q[$];
  int          fail_count, compares, seed, k;

  always #5 sys_clk = ~sys_clk;
  // weak pull-up wins only when nobody drives
  assign line = d_oe ? d_out : (h_oe && !rel) ? h_out : pull;

  receiver_serial_control_port #(.TRACK_CYCLES(8)) i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(1'b1),
    .select_n_pin(sel_n), .serial_clock_pin(sclk), .serial_data_line_in(line),
    .serial_data_line_out(d_out), .serial_data_line_oe(d_oe),
    .serial_data_line_pullup(pull), .amplitude_demod_in(amp_in),
    .frequency_demod_in(frq_in), .amplitude_data_output(ado),
    .frequency_data_output(fdo), .agc_gain_switch(agc), .module_power_on(pwr_on),
    .deep_sleep(sleep), .peak_track_enable(track), .crystal_divisor(divisor),
    .drx_timer_start(discontinuous_receive_mode));

  host_mcu_model i_host (
    .sys_clk(sys_clk), .req(req), .cmd(cmd), .addr(addr), .data(data), .nbits(nbits),
    .rb(rb), .src(src), .done(done), .rd_byte(rd_byte), .select_n_pin(sel_n),
    .serial_clock_pin(sclk), .data_out(h_out), .data_oe(h_oe), .data_wire(line),
    .ask_out(ado), .fsk_out(fdo));

  task summarize;
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // kind: 0 read byte, 1 divisor, 2 power, 3 track, 4 timer start, 7 nothing to check
  task xfer(input logic [3:0] c, input logic [3:0] a, input logic [7:0] v,
            input logic [4:0] n, input logic r, input logic [1:0] s,
            input int kd, input logic [7:0] e);
    int w;
    kind_q.push_back(kd);
    exp_q.push_back(e);
    @(posedge sys_clk);
    {cmd, addr, data, nbits, rb, src} <= {c, a, v, n, r, s};
    req <= 1'b1;
    @(posedge sys_clk);
    req <= 1'b0;
    w = 0;
    while (done !== 1'b1 && w < 2000) begin
      @(posedge sys_clk);
      w++;
    end
    if (w >= 2000)
      fail_count++;
  endtask

  task rd3(input logic [3:0] a, input logic [4:0] n, input logic [7:0] e);
    xfer(rx_ctl_pkg::CMD_READ, a, 8'h00, 5'h10, 1'b0, 2'h0, 7, 8'h00);
    xfer(rx_ctl_pkg::CMD_NOP, 4'h0, 8'h00, n, 1'b1, 2'h0, 0, e);
  endtask

  task probe(input int kd, input logic [7:0] e);
    kind_q.push_back(kd);
    exp_q.push_back(e);
    chk <= 1'b1;
    @(posedge sys_clk);
    chk <= 1'b0;
  endtask

  always @(posedge sys_clk) begin
    amp_in <= 1'($random(seed));
    frq_in <= 1'($random(seed));
  end

  always @(posedge sys_clk) begin
    if ((done === 1'b1 || chk === 1'b1) && kind_q.size() > 0) begin
      k = kind_q.pop_front();
      d = exp_q.pop_front();
      case (k)
        0: obs = rd_byte;
        1: obs = divisor;
        2: obs = {sleep, pwr_on};
        4: obs = {7'h00, discontinuous_receive_mode};
        default: obs = {6'h00, track};
      endcase
      if (k != 7) begin
        compares++;
        if (obs !== d) begin
          fail_count++;
          $display("CHECK FAILED t=%0t exp=%h got=%h", $time, d, obs);
        end
      end
    end
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    summarize();
  end

  initial begin
    logic [7:0] v, p;
    seed = 2;
    {resetn, req, chk, agc, rel} = 5'h00;
    {cmd, addr, data, nbits, rb, src} = 24'h000000;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rd3(rx_ctl_pkg::REG_LAST, 5'h10, 8'h0D);
    rd3(rx_ctl_pkg::REG_POWER, 5'h08, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      xfer(rx_ctl_pkg::CMD_WRITE, rx_ctl_pkg::REG_DIVISOR, v, 5'h10, 1'b0, 2'h0, 1, v);
      rd3(rx_ctl_pkg::REG_DIVISOR, (i % 2) ? 5'h08 : 5'h10, v);
    end
    for (int c = 0; c < 16; c++)
      if (c == 0 || c > 3)
        xfer(4'(c), rx_ctl_pkg::REG_DIVISOR, ~v, 5'h10, 1'b0, 2'h0, 1, v);
    xfer(rx_ctl_pkg::CMD_WRITE, rx_ctl_pkg::REG_DIVISOR, ~v, 5'h08, 1'b0, 2'h0, 1, v);
    xfer(rx_ctl_pkg::CMD_WRITE, rx_ctl_pkg::REG_DIVISOR, 8'h5F, 5'h10, 1'b0, 2'h0, 1, 8'h5F);
    for (int j = 0; j < 4; j++) begin
      p = (j == 0) ? 8'hFE : (j == 1) ? 8'hFF : (j == 2) ? 8'h06 : 8'h00;
      xfer(rx_ctl_pkg::CMD_WRITE, rx_ctl_pkg::REG_POWER, p, 5'h10, 1'b0, 2'h0, 2,
           p[0] ? 8'h80 : {1'b0, p[7:1]});
    end
    for (int t = 1; t < 5; t++)
      xfer(rx_ctl_pkg::CMD_WRITE, rx_ctl_pkg::REG_CONTROL, 8'(t % 4), 5'h10, 1'b0, 2'h0, 3,
           8'(t % 4));
    xfer(rx_ctl_pkg::CMD_WRITE, rx_ctl_pkg::REG_CONFIG, 8'h04, 5'h10, 1'b0, 2'h0, 7, 8'h00);
    xfer(rx_ctl_pkg::CMD_READ, rx_ctl_pkg::REG_DIVISOR, 8'h00, 5'h10, 1'b0, 2'h1, 0, 8'h5F);
    xfer(rx_ctl_pkg::CMD_WRITE, rx_ctl_pkg::REG_CONFIG, 8'h08, 5'h10, 1'b0, 2'h0, 7, 8'h00);
    xfer(rx_ctl_pkg::CMD_READ, rx_ctl_pkg::REG_DIVISOR, 8'h00, 5'h10, 1'b0, 2'h2, 0, 8'h5F);
    // receive timer may only start once the deselected line floats up
    xfer(rx_ctl_pkg::CMD_WRITE, rx_ctl_pkg::REG_CONFIG, 8'h02, 5'h10, 1'b0, 2'h0, 7, 8'h00);
    rel <= 1'b1;
    repeat (5) @(posedge sys_clk);
    probe(4, 8'h01);
    rel <= 1'b0;
    repeat (5) @(posedge sys_clk);
    probe(4, 8'h00);
    xfer(rx_ctl_pkg::CMD_WRITE, rx_ctl_pkg::REG_CONFIG, 8'h00, 5'h10, 1'b0, 2'h0, 7, 8'h00);
    agc <= 1'b1;
    repeat (7) @(posedge sys_clk);
    probe(3, 8'h03);
    repeat (20) @(posedge sys_clk);
    probe(3, 8'h00);
    agc <= 1'b0;
    xfer(rx_ctl_pkg::CMD_RESET, 4'h0, 8'h00, 5'h08, 1'b0, 2'h0, 1, 8'h00);
    rd3(rx_ctl_pkg::REG_DIVISOR, 5'h10, 8'h00);
    repeat (20) @(posedge sys_clk);
    summarize();
  end
endmodule // receiver_serial_control_port_tb

// ==== hw/receiver_serial_control_port.sv ====
`timescale 1ns/10ps
module receiver_serial_control_port #(
  parameter int TRACK_CYCLES = rx_ctl_pkg::TRACK_PULSE_CYC
) (
  // clock, reset, enable
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       clk_en,
  // serial control pins
  input  wire logic       select_n_pin,
  input  wire logic       serial_clock_pin,
  input  wire logic       serial_data_line_in,
  output logic            serial_data_line_out,
  output logic            serial_data_line_oe,
  output logic            serial_data_line_pullup,
  // demodulated data
  input  wire logic       amplitude_demod_in,
  input  wire logic       frequency_demod_in,
  output logic            amplitude_data_output,
  output logic            frequency_data_output,
  // analog control
  input  wire logic       agc_gain_switch,
  output logic [6:0]      module_power_on,
  output logic            deep_sleep,
  output logic [1:0]      peak_track_enable,
  output logic [7:0]      crystal_divisor,
  output logic            drx_timer_start
);

  logic [rx_ctl_pkg::SYNC_W-1:0] sync1_q;
  logic [rx_ctl_pkg::SYNC_W-1:0] sync2_q;
  logic                          cs_p_q;
  logic                          sclk_p_q;
  logic                          agc_p_q;
  logic [4:0]                    bit_cnt_q;
  logic [7:0]                    shift_in_q;
  logic [7:0]                    hdr_q;
  logic [7:0]                    tx_q;
  logic                          read_pend_q;
  logic                          readback_q;
  logic                          fw_read_q;
  logic                          reset_arm_q;
  logic                          soft_rst_q;
  logic [7:0]                    reg_q [0:rx_ctl_pkg::NUM_REGS-1];
  logic                          sleep_p_q;
  logic [rx_ctl_pkg::TRACK_CNT_W-1:0] track_cnt_q;
  logic                          sdo_q;
  logic                          sdo_oe_q;
  logic                          pullup_q;
  logic                          ask_out_q;
  logic                          fsk_out_q;
  logic [6:0]                    power_on_q;
  logic                          deep_sleep_q;
  logic [1:0]                    track_q;
  logic                          drx_start_q;

  // synchronised pins: cs, sclk, data, agc, ask, fsk
  wire cs_s   = sync2_q[0];
  wire sclk_s = sync2_q[1];
  wire sdin_s = sync2_q[2];
  wire agc_s  = sync2_q[3];
  wire ask_s  = sync2_q[4];
  wire fsk_s  = sync2_q[5];

  wire cs_fall   = !cs_s && cs_p_q;
  wire cs_rise   = cs_s && !cs_p_q;
  wire sclk_rise = sclk_s && !sclk_p_q && !cs_s;
  wire sclk_fall = !sclk_s && sclk_p_q && !cs_s;

  wire [7:0] new_byte  = {shift_in_q[6:0], sdin_s};
  wire       hdr_done  = sclk_rise && !readback_q && (bit_cnt_q == rx_ctl_pkg::HDR_LAST_BIT);
  wire       data_done = sclk_rise && !readback_q && (bit_cnt_q == rx_ctl_pkg::FRAME_LAST_BIT);
  wire [3:0] new_cmd   = new_byte[7:4];
  wire [3:0] hdr_cmd   = hdr_q[7:4];
  wire [3:0] wr_addr   = hdr_q[3:0];
  wire [7:0] wr_data   = new_byte;

  wire sleep_bit = reg_q[rx_ctl_pkg::REG_POWER][rx_ctl_pkg::PWR_SLEEP_BIT];
  wire drx_bit   = reg_q[rx_ctl_pkg::REG_CONFIG][rx_ctl_pkg::CFG_DRX_BIT];
  wire ask_sel   = reg_q[rx_ctl_pkg::REG_CONFIG][rx_ctl_pkg::CFG_ASK_SEL_BIT];
  wire fsk_sel   = reg_q[rx_ctl_pkg::REG_CONFIG][rx_ctl_pkg::CFG_FSK_SEL_BIT];
  wire four_wire = ask_sel || fsk_sel;

  // writes only land on mapped, writable addresses; other codes do nothing
  wire wr_ok      = (wr_addr <= rx_ctl_pkg::REG_LAST) && (wr_addr != rx_ctl_pkg::REG_STATUS);
  wire write_fire = data_done && (hdr_cmd == rx_ctl_pkg::CMD_WRITE) && wr_ok;
  wire read_cmd   = hdr_done && (new_cmd == rx_ctl_pkg::CMD_READ);
  wire reset_cmd  = hdr_done && (new_cmd == rx_ctl_pkg::CMD_RESET);

  wire       track_auto = (track_cnt_q != '0);
  wire [7:0] status_val = {5'h00, read_pend_q, track_auto, sleep_bit};
  wire [3:0] rd_addr    = read_cmd ? new_byte[3:0] : hdr_q[3:0];
  wire [7:0] rd_data    = (rd_addr == rx_ctl_pkg::REG_STATUS) ? status_val :
                          (rd_addr <= rx_ctl_pkg::REG_LAST)   ? reg_q[rd_addr] : 8'h00;

  // sleep exit stands in for leaving the receive sleep phase
  wire track_trig = (sleep_p_q && !sleep_bit) || (agc_s && !agc_p_q);
  wire [1:0] track_d = {reg_q[rx_ctl_pkg::REG_CONTROL][rx_ctl_pkg::CTL_TRK_FSK_BIT],
                        reg_q[rx_ctl_pkg::REG_CONTROL][rx_ctl_pkg::CTL_TRK_ASK_BIT]}
                       | {2{track_auto}};

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      // select sits at its idle high level, so no false select edge follows reset
      sync1_q  <= rx_ctl_pkg::SYNC_W'(1);
      sync2_q  <= rx_ctl_pkg::SYNC_W'(1);
      cs_p_q   <= 1'b1;
      sclk_p_q <= 1'b0;
      agc_p_q  <= 1'b0;
    end else if (clk_en) begin
      sync1_q  <= {frequency_demod_in, amplitude_demod_in, agc_gain_switch,
                   serial_data_line_in, serial_clock_pin, select_n_pin};
      sync2_q  <= sync1_q;
      cs_p_q   <= cs_s;
      sclk_p_q <= sclk_s;
      agc_p_q  <= agc_s;
    end
  end

  // frame receiver
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_q  <= '0;
      shift_in_q <= '0;
      hdr_q      <= '0;
    end else if (clk_en) begin
      if (cs_fall) begin
        bit_cnt_q <= '0;
      end else if (sclk_rise) begin
        shift_in_q <= new_byte;
        if (bit_cnt_q != rx_ctl_pkg::BIT_CNT_MAX) begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
        end
        if (hdr_done) begin
          hdr_q <= new_byte;
        end
      end
    end
  end

  // read control and transmit shifter
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      read_pend_q <= 1'b0;
      readback_q  <= 1'b0;
      fw_read_q   <= 1'b0;
      tx_q        <= '0;
    end else if (clk_en) begin
      if (cs_fall && read_pend_q) begin
        readback_q  <= 1'b1;
        read_pend_q <= 1'b0;
        tx_q        <= rd_data;
      end else if (read_cmd && four_wire) begin
        fw_read_q <= 1'b1;
        tx_q      <= rd_data;
      end else if (read_cmd) begin
        read_pend_q <= 1'b1;
      end else if (sclk_fall && (readback_q || fw_read_q)) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
      if (cs_rise) begin
        readback_q <= 1'b0;
        fw_read_q  <= 1'b0;
      end
    end
  end

  // master reset stands until select goes low again
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reset_arm_q <= 1'b0;
      soft_rst_q  <= 1'b0;
    end else if (clk_en) begin
      if (reset_cmd) begin
        reset_arm_q <= 1'b1;
      end else if (cs_rise) begin
        reset_arm_q <= 1'b0;
      end
      if (cs_rise && reset_arm_q) begin
        soft_rst_q <= 1'b1;
      end else if (cs_fall) begin
        soft_rst_q <= 1'b0;
      end
    end
  end

  // register file
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < rx_ctl_pkg::NUM_REGS; i++) begin
        reg_q[i] <= rx_ctl_pkg::REG_RST[i];
      end
    end else if (clk_en) begin
      if (soft_rst_q) begin
        for (int i = 0; i < rx_ctl_pkg::NUM_REGS; i++) begin
          reg_q[i] <= rx_ctl_pkg::REG_RST[i];
        end
      end else if (write_fire) begin
        reg_q[wr_addr] <= wr_data;
      end
    end
  end

  // automatic peak tracking pulse
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sleep_p_q   <= 1'b0;
      track_cnt_q <= '0;
    end else if (clk_en) begin
      sleep_p_q <= sleep_bit;
      if (track_trig) begin
        track_cnt_q <= rx_ctl_pkg::TRACK_CNT_W'(TRACK_CYCLES);
      end else if (track_auto) begin
        track_cnt_q <= track_cnt_q - 1'b1;
      end
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sdo_q        <= 1'b0;
      sdo_oe_q     <= 1'b0;
      pullup_q     <= 1'b1;
      ask_out_q    <= 1'b0;
      fsk_out_q    <= 1'b0;
      power_on_q   <= '0;
      deep_sleep_q <= 1'b0;
      track_q      <= '0;
      drx_start_q  <= 1'b0;
    end else if (clk_en) begin
      sdo_q        <= readback_q && tx_q[7];
      sdo_oe_q     <= readback_q;
      pullup_q     <= 1'b1;
      ask_out_q    <= (ask_sel && fw_read_q) ? tx_q[7] : ask_s;
      fsk_out_q    <= (fsk_sel && fw_read_q) ? tx_q[7] : fsk_s;
      power_on_q   <= sleep_bit ? 7'h00 : reg_q[rx_ctl_pkg::REG_POWER][7:1];
      deep_sleep_q <= sleep_bit;
      track_q      <= track_d;
      // host keeps the line low while deselected so this stays quiet
      drx_start_q  <= drx_bit && cs_s && sdin_s;
    end
  end

  assign serial_data_line_out    = sdo_q;
  assign serial_data_line_oe     = sdo_oe_q;
  assign serial_data_line_pullup = pullup_q;
  assign amplitude_data_output   = ask_out_q;
  assign frequency_data_output   = fsk_out_q;
  assign module_power_on         = power_on_q;
  assign deep_sleep              = deep_sleep_q;
  assign peak_track_enable       = track_q;
  assign crystal_divisor         = reg_q[rx_ctl_pkg::REG_DIVISOR];
  assign drx_timer_start         = drx_start_q;

  sequence wr_frame_end;
    write_fire && clk_en && !soft_rst_q;
  endsequence

  sequence readback_start;
    cs_fall && read_pend_q && clk_en;
  endsequence

  frame_count_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (cs_fall && clk_en) |=> (bit_cnt_q == 5'h00))
    else $error("bit counter not cleared at select low");

  write_store_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_frame_end |=> (reg_q[$past(wr_addr)] == $past(wr_data)))
    else $error("write data not stored");

  sleep_power_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sleep_bit && clk_en) |=> (module_power_on == 7'h00) && deep_sleep)
    else $error("power on during deep sleep");

  follow_power_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!sleep_bit && !drx_bit && clk_en) |=> (module_power_on == $past(reg_q[0][7:1])))
    else $error("module power not following enables");

  reset_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (soft_rst_q && clk_en) |=> (reg_q[3] == 8'h00) && (reg_q[10] == 8'h0D))
    else $error("master reset not restoring registers");

  reset_select_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (cs_rise && reset_arm_q && clk_en) |=> soft_rst_q)
    else $error("master reset not raised at deselect");

  readback_go_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    readback_start |=> readback_q && (tx_q == $past(rd_data)))
    else $error("readback frame not started");

  line_drive_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en |=> (serial_data_line_oe == $past(readback_q)))
    else $error("data line drive mismatch");

  four_wire_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (fw_read_q && ask_sel && clk_en) |=> (amplitude_data_output == $past(tx_q[7])))
    else $error("four-wire read data missing");

  track_pulse_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (track_trig && clk_en) |=> track_auto ##1 (peak_track_enable == 2'b11 || !clk_en))
    else $error("automatic tracking pulse missing");

endmodule // receiver_serial_control_port

// ==== hw/rx_ctl_pkg.sv ====
package rx_ctl_pkg;
  // frame layout
  localparam int          DATA_W         = 8;
  localparam int          ADDR_W         = 4;
  localparam int          NUM_REGS       = 11;
  localparam logic [4:0]  HDR_LAST_BIT   = 5'h07;
  localparam logic [4:0]  FRAME_LAST_BIT = 5'h0F;
  localparam logic [4:0]  BIT_CNT_MAX    = 5'h1F;
  localparam int          SYNC_W         = 6;

  // command codes
  localparam logic [3:0]  CMD_NOP        = 4'h0;
  localparam logic [3:0]  CMD_WRITE      = 4'h1;
  localparam logic [3:0]  CMD_READ       = 4'h2;
  localparam logic [3:0]  CMD_RESET      = 4'h3;

  // register addresses
  localparam logic [3:0]  REG_POWER      = 4'h0;
  localparam logic [3:0]  REG_CONFIG     = 4'h1;
  localparam logic [3:0]  REG_CONTROL    = 4'h2;
  localparam logic [3:0]  REG_DIVISOR    = 4'h3;
  localparam logic [3:0]  REG_STATUS     = 4'h9;
  localparam logic [3:0]  REG_LAST       = 4'hA;

  // field positions
  localparam int          PWR_SLEEP_BIT  = 0;
  localparam int          PWR_ASKPD_BIT  = 1;
  localparam int          PWR_FSKPD_BIT  = 2;
  localparam int          CFG_DRX_BIT    = 1;
  localparam int          CFG_ASK_SEL_BIT = 2;
  localparam int          CFG_FSK_SEL_BIT = 3;
  localparam int          CTL_TRK_ASK_BIT = 0;
  localparam int          CTL_TRK_FSK_BIT = 1;
  localparam int          ST_SLEEP_BIT   = 0;
  localparam int          ST_TRACK_BIT   = 1;
  localparam int          ST_RDPEND_BIT  = 2;

  // values after reset, indexed by address
  localparam logic [7:0]  REG_RST [0:NUM_REGS-1] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h0D
  };

  // automatic peak tracking pulse
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          TRACK_PULSE_NS = 10000;
  localparam int          TRACK_PULSE_CYC =
    (TRACK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TRACK_CNT_W    = 10;
endpackage
